// File: rtl/load_group_defines.svh
/*
 * Constants for the load-group decode and execute core: opcodes, selector codes,
 * machine-cycle lengths, flag positions and the software register port map.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef LOAD_GROUP_DEFINES_SVH
`define LOAD_GROUP_DEFINES_SVH


// ==========================================================
// Opcodes
`define OP_PFX_FIRST 8'hDD
`define OP_PFX_SECOND 8'hFD
`define OP_PFX_EXT 8'hED
`define OP_SP_LOAD 8'hF9
`define OP_HALT_SLOT 8'h76
`define EXT_VEC_LOAD 8'h47
`define EXT_RFSH_LOAD 8'h4F
`define EXT_COPY_ONCE 8'hA8
`define EXT_COPY_RPT 8'hB8

// ==========================================================
// Selector codes and index prefixes
`define SEL_MEM 3'h6
`define SEL_A 3'h7
`define PFX_NONE 2'h0
`define PFX_FIRST 2'h1
`define PFX_SECOND 2'h2

// ==========================================================
// Machine-cycle lengths in clock states (one state per clock)
`define T_MEM 2'h3
`define T_INT_SHORT 2'h1
`define T_INT_IDX 2'h2
`define T_INT_RFSH 2'h2

// ==========================================================
// Flag bit positions
`define FLAG_H 4
`define FLAG_PV 2
`define FLAG_N 1

// ==========================================================
// Software register port map (byte wide)
`define RA_I 5'h08
`define RA_R 5'h09
`define RA_IXH 5'h0A
`define RA_IXL 5'h0B
`define RA_IYH 5'h0C
`define RA_IYL 5'h0D
`define RA_SPH 5'h0E
`define RA_SPL 5'h0F
`define RA_PCH 5'h10
`define RA_PCL 5'h11
`define RA_CTRL 5'h12
`define RA_STAT 5'h13
`define CTRL_RUN 0
`define CTRL_IE 1
`define STAT_BUSY 0
`define STAT_BADOP 1
`define STAT_RPT 2

// ==========================================================
// Reset values
`define PC_RST 16'h0000
`define SP_RST 16'h0000

`endif

// File: rtl/load_group_pkg.sv
/*
 * Types for the load-group core: sequencer states and follow-up actions.
 * Assumes the defines header sits beside it.
 */
`include "load_group_defines.svh"

package load_group_pkg;
	// ==========================================================
	// Machine-cycle kinds of the sequencer
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, // Not running
		ST_FETCH = 4'h1, // Opcode or prefix fetch
		ST_ED = 4'h2, // Second byte after extension prefix
		ST_DISP = 4'h3, // Displacement read
		ST_IMM = 4'h4, // Immediate read
		ST_MRD = 4'h5, // Data read
		ST_MWR = 4'h6, // Data write
		ST_INT = 4'h7 // Internal states
	} state_e;

	// ==========================================================
	// What follows an internal cycle
	typedef enum logic [1:0] {
		NX_DONE = 2'h0,
		NX_MRD = 2'h1,
		NX_MWR = 2'h2,
		NX_RPT = 2'h3
	} next_e;
endpackage : load_group_pkg

// File: rtl/index_addr_calc.sv
/*
 * Pointer select and indexed address adder.
 * Assumes the prefix code from the sequencer and a displacement byte off the bus.
 */
`timescale 1ns/1ps
`default_nettype none
`include "load_group_defines.svh"

module index_addr_calc (
	input wire logic [1:0] pfx, // Active index prefix
	input wire logic [15:0] hl, // Source pointer pair
	input wire logic [15:0] ix, // First index register
	input wire logic [15:0] iy, // Second index register
	input wire logic [7:0] disp, // Signed displacement
	output logic [15:0] ptr, // Prefix-selected pointer
	output logic [15:0] addr // Pointer plus displacement
);
	// ==========================================================
	// Pointer choice
	always_comb begin
		case (pfx)
			`PFX_FIRST: ptr = ix; // First index
			`PFX_SECOND: ptr = iy; // Second index
			default: ptr = hl; // No prefix
		endcase
	end

	assign addr = ptr + {{8{disp[7]}}, disp};
endmodule : index_addr_calc

`default_nettype wire

// File: rtl/load_group_decode_execute.sv
/*
 * Decode and execute core for the load group: register, immediate and memory
 * moves, vector and refresh register loads, stack pointer loads and the
 * decrementing block copy, single and repeating.
 * Assumes a synchronous memory that holds read data valid by the third state
 * of each three-state cycle, and a software master on the register port.
 */
`timescale 1ns/1ps
`default_nettype none
`include "load_group_defines.svh"

module load_group_decode_execute
	import load_group_pkg::*;
(
	input wire logic clock, // 20 MHz core clock
	input wire logic rstn, // Asynchronous reset, low
	output logic [15:0] mem_addr, // Memory address
	output logic mem_rd, // Read cycle in progress
	output logic mem_wr, // Write cycle in progress
	output logic mem_m1, // Opcode fetch cycle
	output logic mem_rfsh, // Refresh cycle
	output logic [7:0] mem_wdata, // Write data
	input wire logic [7:0] mem_rdata, // Read data
	input wire logic irq_req, // Interrupt request pin
	output logic irq_ack, // Interrupt accepted pulse
	input wire logic [4:0] reg_addr, // Register port address
	input wire logic [7:0] reg_wdata, // Register port write data
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	output logic [7:0] reg_rdata // Read data, one cycle later
);
	// ==========================================================
	// State
	state_e state_q; // Current machine cycle
	next_e next_q; // Action after internal cycle
	logic [1:0] tcnt_q; // State within cycle
	logic [1:0] len_q; // Length of this cycle
	logic [1:0] pfx_q; // Index prefix seen
	logic ed_q; // Extended opcode in progress
	logic [7:0] op_q; // Current opcode
	logic [15:0] ea_q; // Effective address
	logic [7:0] gp_q [0:7]; // Registers by selector, slot 6 holds flags
	logic [7:0] i_q; // Interrupt vector register
	logic [7:0] r_q; // Refresh register
	logic [15:0] ix_q; // First index register
	logic [15:0] iy_q; // Second index register
	logic [15:0] sp_q; // Stack top pointer
	logic [15:0] pc_q; // Program counter
	logic run_q; // Software run enable
	logic ie_q; // Interrupt enable
	logic bad_op_q; // Sticky unsupported opcode
	logic irq_meta_q; // Synchroniser first stage
	logic irq_sync_q; // Synchroniser second stage
	logic irq_ack_q; // Accept pulse
	logic [15:0] mem_addr_q; // Bus address
	logic mem_rd_q; // Bus read
	logic mem_wr_q; // Bus write
	logic mem_m1_q; // Bus fetch marker
	logic mem_rfsh_q; // Bus refresh marker
	logic [7:0] mem_wdata_q; // Bus write data
	logic [7:0] reg_rdata_q; // Port read data

	// ==========================================================
	// Derived values
	logic [15:0] pc_inc; // Next program counter
	logic [15:0] bc; // Byte count pair
	logic [15:0] de; // Target pointer pair
	logic [15:0] hl; // Source pointer pair
	logic [15:0] bc_dec; // Decremented count
	logic [15:0] ptr; // Prefix-selected pointer
	logic [15:0] idx_addr; // Indexed address
	logic [7:0] r_inc; // Refresh register after one step
	logic tlast; // Last state of this cycle

	assign pc_inc = pc_q + 16'h0001;
	assign bc = {gp_q[0], gp_q[1]};
	assign de = {gp_q[2], gp_q[3]};
	assign hl = {gp_q[4], gp_q[5]};
	assign bc_dec = bc - 16'h0001;
	assign r_inc = {r_q[7], r_q[6:0] + 7'h01};
	assign tlast = (tcnt_q == len_q - 2'h1);

	assign mem_addr = mem_addr_q;
	assign mem_rd = mem_rd_q;
	assign mem_wr = mem_wr_q;
	assign mem_m1 = mem_m1_q;
	assign mem_rfsh = mem_rfsh_q;
	assign mem_wdata = mem_wdata_q;
	assign irq_ack = irq_ack_q;
	assign reg_rdata = reg_rdata_q;

	// Pointer and indexed address
	index_addr_calc u_idx (
		.pfx(pfx_q),
		.hl(hl),
		.ix(ix_q),
		.iy(iy_q),
		.disp(mem_rdata),
		.ptr(ptr),
		.addr(idx_addr)
	);

	// ==========================================================
	// Decode helpers
	// selector 110 is memory
	function automatic logic sel_is_mem(input logic [2:0] sel);
		sel_is_mem = (sel == `SEL_MEM);
	endfunction : sel_is_mem

	// Enter a machine cycle with its bus signals
	task automatic enter(input state_e s, input logic [15:0] a, input logic [1:0] len);
		state_q <= s;
		mem_addr_q <= a;
		mem_rd_q <= (s == ST_FETCH) || (s == ST_ED) || (s == ST_DISP) || (s == ST_IMM) || (s == ST_MRD);
		mem_wr_q <= (s == ST_MWR);
		mem_m1_q <= (s == ST_FETCH) || (s == ST_ED);
		mem_rfsh_q <= 1'b0;
		tcnt_q <= 2'h0;
		len_q <= len;
	endtask : enter

	// Instruction boundary: take an interrupt, then fetch or idle
	task automatic start_instr(input logic [15:0] a);
		pfx_q <= `PFX_NONE;
		ed_q <= 1'b0;
		if (run_q) begin
			if (irq_sync_q && ie_q) begin
				irq_ack_q <= 1'b1;
				ie_q <= 1'b0;
			end
			enter(ST_FETCH, a, `T_MEM);
		end else begin
			enter(ST_IDLE, a, `T_MEM);
		end
	endtask : start_instr

	// ==========================================================
	// Interrupt pin synchroniser
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			irq_meta_q <= 1'b0;
			irq_sync_q <= 1'b0;
		end else begin
			irq_meta_q <= irq_req;
			irq_sync_q <= irq_meta_q;
		end
	end

	// ==========================================================
	// Sequencer, register file and software writes
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			next_q <= NX_DONE;
			tcnt_q <= 2'h0;
			len_q <= `T_MEM;
			pfx_q <= `PFX_NONE;
			ed_q <= 1'b0;
			op_q <= 8'h00;
			ea_q <= 16'h0000;
			for (int k = 0; k < 8; k++) begin
				gp_q[k] <= 8'h00;
			end
			i_q <= 8'h00;
			r_q <= 8'h00;
			ix_q <= 16'h0000;
			iy_q <= 16'h0000;
			sp_q <= `SP_RST;
			pc_q <= `PC_RST;
			run_q <= 1'b0;
			ie_q <= 1'b0;
			bad_op_q <= 1'b0;
			irq_ack_q <= 1'b0;
			mem_addr_q <= 16'h0000;
			mem_rd_q <= 1'b0;
			mem_wr_q <= 1'b0;
			mem_m1_q <= 1'b0;
			mem_rfsh_q <= 1'b0;
			mem_wdata_q <= 8'h00;
		end else begin
			irq_ack_q <= 1'b0;
			// Software writes; architectural state only while idle
			if (reg_wr) begin
				if (reg_addr == `RA_CTRL) begin
					run_q <= reg_wdata[`CTRL_RUN];
					ie_q <= reg_wdata[`CTRL_IE];
				end else if (reg_addr == `RA_STAT) begin
					if (reg_wdata[`STAT_BADOP]) begin
						bad_op_q <= 1'b0;
					end
				end else if (state_q == ST_IDLE) begin
					case (reg_addr)
						`RA_I: i_q <= reg_wdata;
						`RA_R: r_q <= reg_wdata;
						`RA_IXH: ix_q[15:8] <= reg_wdata;
						`RA_IXL: ix_q[7:0] <= reg_wdata;
						`RA_IYH: iy_q[15:8] <= reg_wdata;
						`RA_IYL: iy_q[7:0] <= reg_wdata;
						`RA_SPH: sp_q[15:8] <= reg_wdata;
						`RA_SPL: sp_q[7:0] <= reg_wdata;
						`RA_PCH: pc_q[15:8] <= reg_wdata;
						`RA_PCL: pc_q[7:0] <= reg_wdata;
						default: begin
							if (reg_addr[4:3] == 2'h0) begin
								gp_q[reg_addr[2:0]] <= reg_wdata;
							end
						end
					endcase
				end
			end
			if (!tlast) begin
				// Middle states; refresh steps the refresh register
				tcnt_q <= tcnt_q + 2'h1;
				if (mem_rfsh_q) begin
					r_q <= r_inc;
					mem_addr_q <= {i_q, r_inc};
				end
			end else begin
				case (state_q)
					ST_IDLE: begin
						if (run_q) begin
							start_instr(pc_q);
						end
					end
					ST_FETCH: begin
						pc_q <= pc_inc;
						r_q <= r_inc;
						op_q <= mem_rdata;
						if (mem_rdata == `OP_PFX_FIRST || mem_rdata == `OP_PFX_SECOND) begin
							// Prefix: fetch the opcode it modifies
							pfx_q <= (mem_rdata == `OP_PFX_FIRST) ? `PFX_FIRST : `PFX_SECOND;
							enter(ST_FETCH, pc_inc, `T_MEM);
						end else if (mem_rdata == `OP_PFX_EXT) begin
							enter(ST_ED, pc_inc, `T_MEM);
						end else if (mem_rdata[7:6] == 2'h1 && mem_rdata != `OP_HALT_SLOT) begin
							if (sel_is_mem(mem_rdata[2:0])) begin
								if (pfx_q != `PFX_NONE) begin
									enter(ST_DISP, pc_inc, `T_MEM);
								end else begin
									enter(ST_MRD, hl, `T_MEM);
								end
							end else if (sel_is_mem(mem_rdata[5:3])) begin
								if (pfx_q != `PFX_NONE) begin
									enter(ST_DISP, pc_inc, `T_MEM);
								end else begin
									ea_q <= hl;
									next_q <= NX_MWR;
									enter(ST_INT, hl, `T_INT_SHORT);
								end
							end else begin
								gp_q[mem_rdata[5:3]] <= gp_q[mem_rdata[2:0]];
								next_q <= NX_DONE;
								enter(ST_INT, pc_inc, `T_INT_SHORT);
							end
						end else if (mem_rdata[7:6] == 2'h0 && sel_is_mem(mem_rdata[2:0])) begin
							if (pfx_q != `PFX_NONE && sel_is_mem(mem_rdata[5:3])) begin
								enter(ST_DISP, pc_inc, `T_MEM);
							end else begin
								enter(ST_IMM, pc_inc, `T_MEM);
							end
						end else if (mem_rdata == `OP_SP_LOAD) begin
							sp_q <= ptr;
							next_q <= NX_DONE;
							enter(ST_INT, pc_inc, `T_INT_SHORT);
						end else begin
							// Outside this group: flag and skip
							bad_op_q <= 1'b1;
							start_instr(pc_inc);
						end
					end
					ST_ED: begin
						pc_q <= pc_inc;
						r_q <= r_inc;
						op_q <= mem_rdata;
						ed_q <= 1'b1;
						case (mem_rdata)
							`EXT_VEC_LOAD: begin
								i_q <= gp_q[`SEL_A];
								start_instr(pc_inc);
							end
							`EXT_RFSH_LOAD: begin
								r_q <= gp_q[`SEL_A];
								start_instr(pc_inc);
							end
							`EXT_COPY_ONCE, `EXT_COPY_RPT: begin
								enter(ST_MRD, hl, `T_MEM);
							end
							default: begin
								bad_op_q <= 1'b1;
								start_instr(pc_inc);
							end
						endcase
					end
					ST_DISP: begin
						pc_q <= pc_inc;
						ea_q <= idx_addr;
						if (op_q[7:6] == 2'h0) begin
							enter(ST_IMM, pc_inc, `T_MEM);
						end else begin
							next_q <= sel_is_mem(op_q[2:0]) ? NX_MRD : NX_MWR;
							enter(ST_INT, idx_addr, `T_INT_IDX);
						end
					end
					ST_IMM: begin
						pc_q <= pc_inc;
						if (sel_is_mem(op_q[5:3])) begin
							enter(ST_MWR, (pfx_q != `PFX_NONE) ? ea_q : hl, `T_MEM);
							mem_wdata_q <= mem_rdata;
						end else begin
							gp_q[op_q[5:3]] <= mem_rdata;
							start_instr(pc_inc);
						end
					end
					ST_MRD: begin
						if (ed_q) begin
							enter(ST_MWR, de, `T_MEM);
							mem_wdata_q <= mem_rdata;
						end else begin
							gp_q[op_q[5:3]] <= mem_rdata;
							start_instr(pc_q);
						end
					end
					ST_MWR: begin
						if (ed_q) begin
							{gp_q[4], gp_q[5]} <= hl - 16'h0001;
							{gp_q[2], gp_q[3]} <= de - 16'h0001;
							{gp_q[0], gp_q[1]} <= bc_dec;
							// parity from count, clear H and N
							gp_q[`SEL_MEM][`FLAG_PV] <= (bc_dec != 16'h0000);
							gp_q[`SEL_MEM][`FLAG_H] <= 1'b0;
							gp_q[`SEL_MEM][`FLAG_N] <= 1'b0;
							// repeat while count nonzero, zero wraps
							if (op_q == `EXT_COPY_RPT && bc_dec != 16'h0000) begin
								next_q <= NX_RPT;
								enter(ST_INT, {i_q, r_q}, `T_INT_RFSH);
								mem_rfsh_q <= 1'b1;
							end else begin
								// final pass ends at 12 states
								start_instr(pc_q);
							end
						end else begin
							start_instr(pc_q);
						end
					end
					ST_INT: begin
						if (mem_rfsh_q) begin
							r_q <= r_inc;
						end
						case (next_q)
							NX_MRD: enter(ST_MRD, ea_q, `T_MEM);
							NX_MWR: begin
								enter(ST_MWR, ea_q, `T_MEM);
								mem_wdata_q <= gp_q[op_q[2:0]];
							end
							NX_RPT: begin
								pc_q <= pc_q - 16'h0002;
								start_instr(pc_q - 16'h0002);
							end
							default: start_instr(pc_q);
						endcase
					end
					default: start_instr(pc_q);
				endcase
			end
		end
	end

	// ==========================================================
	// Software register reads
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`RA_I: reg_rdata_q <= i_q;
				`RA_R: reg_rdata_q <= r_q;
				`RA_IXH: reg_rdata_q <= ix_q[15:8];
				`RA_IXL: reg_rdata_q <= ix_q[7:0];
				`RA_IYH: reg_rdata_q <= iy_q[15:8];
				`RA_IYL: reg_rdata_q <= iy_q[7:0];
				`RA_SPH: reg_rdata_q <= sp_q[15:8];
				`RA_SPL: reg_rdata_q <= sp_q[7:0];
				`RA_PCH: reg_rdata_q <= pc_q[15:8];
				`RA_PCL: reg_rdata_q <= pc_q[7:0];
				`RA_CTRL: reg_rdata_q <= {6'h00, ie_q, run_q};
				`RA_STAT: reg_rdata_q <= {5'h00, ed_q && op_q == `EXT_COPY_RPT, bad_op_q, state_q != ST_IDLE};
				default: begin
					// General registers, others read zero
					reg_rdata_q <= (reg_addr[4:3] == 2'h0) ? gp_q[reg_addr[2:0]] : 8'h00;
				end
			endcase
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end
endmodule : load_group_decode_execute

`default_nettype wire

// File: testbench/load_group_sva.sv
/*
 * Concurrent checks on the load-group core's memory bus and interrupt pulse.
 * Assumes it is bound to the core and sees only the core's ports.
 */
`timescale 1ns/1ps
`default_nettype none

module load_group_sva (
	input wire logic clock, // Core clock
	input wire logic rstn, // Asynchronous reset, low
	input wire logic [15:0] mem_addr, // Memory address
	input wire logic mem_rd, // Read cycle
	input wire logic mem_wr, // Write cycle
	input wire logic mem_m1, // Opcode fetch
	input wire logic mem_rfsh, // Refresh states
	input wire logic [7:0] mem_wdata, // Write data
	input wire logic irq_ack // Interrupt accepted
);
	// ==========================================================
	// One clock domain, reset disables everything
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	// ==========================================================
	// Machine cycle shape
	chk_wr_three:
		assert property ($rose(mem_wr) |-> mem_wr [*3] ##1 !mem_wr) else $error("write cycle not three states");
	chk_rd_three:
		assert property ($rose(mem_rd) |-> mem_rd [*3]) else $error("read cycle shorter than three states");
	chk_wr_steady:
		assert property (mem_wr && $past(mem_wr) |-> $stable(mem_addr) && $stable(mem_wdata))
			else $error("write address or data moved");
	chk_no_rdwr:
		assert property (!(mem_rd && mem_wr)) else $error("read and write together");

	// ==========================================================
	// Refresh pair after each continuing copy pass
	chk_rfsh_two:
		assert property ($rose(mem_rfsh) |-> mem_rfsh ##1 mem_rfsh ##1 !mem_rfsh) else $error("refresh not two states");
	chk_rfsh_quiet:
		assert property (mem_rfsh |-> !mem_rd && !mem_wr) else $error("bus strobe during refresh");
	chk_rfsh_after_wr:
		assert property ($rose(mem_rfsh) |-> $past(mem_wr) && !$past(mem_wr, 4))
			else $error("refresh not after a three-state write");
	chk_rfsh_refetch:
		assert property ($fell(mem_rfsh) |-> (mem_m1 && mem_rd) || !(mem_rd || mem_wr))
			else $error("no refetch after refresh");

	// ==========================================================
	// Interrupt acceptance is a lone pulse
	chk_ack_lone:
		assert property (irq_ack |=> !irq_ack [*8]) else $error("interrupt accepted twice");
endmodule : load_group_sva

bind load_group_decode_execute load_group_sva i_sva (.clock(clock), .rstn(rstn), .mem_addr(mem_addr),
	.mem_rd(mem_rd), .mem_wr(mem_wr), .mem_m1(mem_m1), .mem_rfsh(mem_rfsh), .mem_wdata(mem_wdata),
	.irq_ack(irq_ack));

`default_nettype wire

// File: testbench/mem_model.sv
/*
 * Byte-wide external memory on the core's bus, no wait states.
 * Assumes the bench preloads it directly; idle read data is scrambled.
 */
`timescale 1ns/1ps
`default_nettype none

module mem_model (
	input wire logic clock, // Core clock
	input wire logic [15:0] mem_addr, // Address
	input wire logic mem_rd, // Read cycle
	input wire logic mem_wr, // Write cycle
	input wire logic [7:0] mem_wdata, // Write data
	output logic [7:0] mem_rdata // Read data
);
	logic [7:0] mem [0:65535]; // Byte store
	logic [7:0] junk_q = 8'hA5; // Idle pattern, moves each cycle

	// Fill with a harmless register move
	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 8'h7F;
	end

	// Store on write, keep the idle pattern moving
	always @(posedge clock) begin
		junk_q <= ~junk_q + 8'h01;
		if (mem_wr === 1'b1) mem[mem_addr] <= mem_wdata;
	end

	// Data only while a read stands
	assign mem_rdata = (mem_rd === 1'b1) ? mem[mem_addr] : junk_q;
endmodule : mem_model

`default_nettype wire

// File: testbench/tb_load_group_decode_execute.sv
/*
 * Self-checking bench for the load-group core: runs short programs from memory.
 * Assumes the core idles after reset and is started and stopped through its control register.
 */
`timescale 1ns/1ps
`default_nettype none
`include "load_group_defines.svh"

module tb_load_group_decode_execute;
	localparam int LIMIT = 40000; // Cycle ceiling
	logic clock, rstn, reg_wr, reg_rd, irq_req, irq_en, wq_on, rd_prev, wr_prev;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, mem_wdata, mem_rdata, f, v, a, d8;
	logic [15:0] mem_addr, hl, de, bc, ix, iy, note;
	logic mem_rd, mem_wr, mem_m1, mem_rfsh, irq_ack;
	logic [2:0] d, s;
	logic [7:0] ref_r [0:7]; // Expected register file
	logic [2:0] codes [0:6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
	logic [7:0] p [$]; // Program bytes
	logic [15:0] rq [$]; // Read notes: mask, value
	logic [23:0] wq [$]; // Write notes: address, data
	int n_mismatch, comparisons, n_wr, n_ack, cycles, n, seed_v;

	load_group_decode_execute i_dut (.clock(clock), .rstn(rstn), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_wr(mem_wr), .mem_m1(mem_m1), .mem_rfsh(mem_rfsh), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.irq_req(irq_req), .irq_ack(irq_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	mem_model i_mem (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	// ==========================================================
	// Clock, 50 ns period
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	// ==========================================================
	// Register port master
	task automatic reg_write(input logic [4:0] ra, input logic [7:0] wd);
		@(posedge clock);
		reg_addr <= ra;
		reg_wdata <= wd;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [4:0] ra, input logic [7:0] ex, input logic [7:0] mk, output logic [7:0] rv);
		@(posedge clock);
		reg_addr <= ra;
		reg_rd <= 1'b1;
		rq.push_back({mk, ex});
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask : reg_read

	task automatic expect_reg(input logic [4:0] ra, input logic [7:0] ex, input logic [7:0] mk);
		logic [7:0] rv;
		reg_read(ra, ex, mk, rv);
	endtask : expect_reg

	task automatic set_pair(input logic [4:0] ra, input logic [15:0] pv);
		reg_write(ra, pv[15:8]);
		reg_write(5'(ra + 5'h01), pv[7:0]);
	endtask : set_pair

	task automatic expect_pair(input logic [4:0] ra, input logic [15:0] pv);
		expect_reg(ra, pv[15:8], 8'hFF);
		expect_reg(5'(ra + 5'h01), pv[7:0], 8'hFF);
	endtask : expect_pair

	// Load a program at 0, run it, count states to the fetch past its end, then stop
	task automatic run(input int states);
		int k;
		logic [7:0] rv;
		for (int i = 0; i < p.size(); i++) i_mem.mem[i] = p[i];
		for (int i = 0; i < 8; i++) i_mem.mem[p.size() + i] = 8'h7F;
		n_wr = 0;
		n_ack = 0;
		k = 0;
		set_pair(`RA_PCH, 16'h0000);
		reg_write(`RA_CTRL, {6'h00, irq_en, 1'b1});
		while (mem_m1 !== 1'b1 && k < 200) begin
			@(posedge clock);
			#1;
			k++;
		end
		k = 0;
		while (k < 3000 && (states == 0 ? n_wr < 3 : !(mem_m1 === 1'b1 && mem_addr === 16'(p.size())))) begin
			@(posedge clock);
			#1;
			k++;
		end
		// A run that never reaches its end is a failure, not a pass
		check(16'(k >= 3000), 16'h0000);
		if (states > 0) check(16'(k), 16'(states));
		reg_write(`RA_CTRL, 8'h00);
		k = 0;
		rv = 8'h01;
		while (rv[0] !== 1'b0 && k < 100) begin
			reg_read(`RA_STAT, 8'h00, 8'h00, rv);
			k++;
		end
		if (wq_on) check(16'(wq.size()), 16'h0000);
	endtask : run

	// ==========================================================
	// Result watcher: read data and memory writes against the notes
	always @(posedge clock) begin
		#1;
		if (rd_prev) begin
			note = rq.pop_front();
			if (note[15:8] != 8'h00) check({8'h00, reg_rdata & note[15:8]}, {8'h00, note[7:0] & note[15:8]});
		end
		rd_prev = reg_rd;
		if (mem_wr === 1'b1 && !wr_prev) begin
			n_wr++;
			if (wq_on && wq.size() > 0) begin
				check(mem_addr, wq[0][23:8]);
				check({8'h00, mem_wdata}, {8'h00, wq.pop_front()[7:0]});
			end
		end
		wr_prev = (mem_wr === 1'b1);
		if (irq_ack === 1'b1) n_ack++;
		cycles++;
		if (cycles >= LIMIT) begin
			n_mismatch++;
			end_of_test();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		{rstn, reg_wr, reg_rd, irq_req, irq_en, rd_prev, wr_prev} = '0;
		{reg_addr, reg_wdata} = '0;
		wq_on = 1'b1;
		seed_v = $urandom(32'hF9BBAA97);
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		// Register moves, then immediate loads, every register selector
		f = 8'($urandom);
		reg_write(5'h06, f);
		for (int k = 0; k < 7; k++) begin
			ref_r[codes[k]] = 8'($urandom);
			reg_write({2'b00, codes[k]}, ref_r[codes[k]]);
		end
		for (int t = 0; t < 2; t++) begin
			p = {};
			for (int k = 0; k < 7; k++) begin
				d = codes[k];
				s = codes[(k + 3) % 7];
				v = 8'($urandom);
				if (t == 0) begin
					p.push_back({2'b01, d, s});
					ref_r[d] = ref_r[s];
				end else begin
					p.push_back({2'b00, d, 3'b110});
					p.push_back(v);
					ref_r[d] = v;
				end
			end
			run(t == 0 ? 28 : 42);
			for (int k = 0; k < 7; k++) expect_reg({2'b00, codes[k]}, ref_r[codes[k]], 8'hFF);
			$display("register move test %0d done", t);
		end
		// Pointer-addressed store immediate, store, load back
		hl = {4'h8, 12'($urandom)};
		set_pair(5'h04, hl);
		v = 8'($urandom);
		wq.push_back({hl, v});
		wq.push_back({hl, ref_r[7]});
		p = {8'h36, v, 8'h77, 8'h46};
		run(22);
		expect_reg(5'h00, ref_r[7], 8'hFF);
		$display("pointer test done");
		// Indexed forms, displacement at both extremes
		ix = {4'h9, 12'($urandom)};
		iy = {4'hA, 12'($urandom)};
		set_pair(`RA_IXH, ix);
		set_pair(`RA_IYH, iy);
		d8 = 8'($urandom % 127);
		a = 8'($urandom);
		i_mem.mem[ix + {8'h00, d8}] = a;
		wq.push_back({ix - 16'h0080, v});
		wq.push_back({iy + 16'h007F, ref_r[7]});
		p = {8'hDD, 8'h36, 8'h80, v, 8'hFD, 8'h70, 8'h7F, 8'hDD, 8'h4E, d8};
		run(43);
		expect_reg(5'h01, a, 8'hFF);
		$display("indexed test done");
		// Vector, refresh and stack pointer loads; flags stay
		// Trailing byte lies outside the group: one fetch, sticky status bit
		p = {8'hED, 8'h47, 8'hED, 8'h4F, 8'hF9, 8'h00};
		run(19);
		expect_reg(`RA_STAT, 8'h02, 8'h02);
		reg_write(`RA_STAT, 8'h02);
		expect_reg(`RA_STAT, 8'h00, 8'h02);
		expect_reg(`RA_I, ref_r[7], 8'hFF);
		expect_reg(`RA_R, ref_r[7], 8'h80);
		expect_pair(`RA_SPH, hl);
		p = {8'hDD, 8'hF9};
		run(7);
		expect_pair(`RA_SPH, ix);
		p = {8'hFD, 8'hF9};
		run(7);
		expect_pair(`RA_SPH, iy);
		expect_reg(5'h06, f, 8'hFF);
		reg_write(5'h1F, 8'hFF);
		expect_reg(5'h1F, 8'h00, 8'hFF);
		$display("special load test done");
		// Copies: once to zero, once non-zero, repeating, repeating under interrupt
		for (int c = 0; c < 4; c++) begin
			bc = (c == 3) ? 16'h0002 : 16'(c + 1);
			n = (c >= 2) ? int'(bc) : 1;
			hl = {4'hB, 12'($urandom)};
			de = {4'hC, 12'($urandom)};
			f = 8'($urandom);
			set_pair(5'h00, bc);
			set_pair(5'h02, de);
			set_pair(5'h04, hl);
			reg_write(5'h06, f);
			for (int i = 0; i < n; i++) begin
				a = 8'($urandom);
				i_mem.mem[hl - 16'(i)] = a;
				wq.push_back({de - 16'(i), a});
			end
			p = {8'hED, (c >= 2) ? 8'hB8 : 8'hA8};
			irq_en = (c == 3);
			@(posedge clock);
			irq_req <= (c == 3);
			run(c == 3 ? -1 : (c == 2 ? 40 : 12));
			irq_req <= 1'b0;
			if (c == 3) check(16'(n_ack), 16'h0001);
			expect_pair(5'h00, bc - 16'(n));
			expect_pair(5'h02, de - 16'(n));
			expect_pair(5'h04, hl - 16'(n));
			expect_reg(5'h06, (f & 8'hE9) | (bc != 16'(n) ? 8'h04 : 8'h00), 8'hFF);
			$display("copy test %0d done", c);
		end
		// Repeating copy from a zero count wraps instead of ending
		irq_en = 1'b0;
		wq_on = 1'b0;
		set_pair(5'h00, 16'h0000);
		p = {8'hED, 8'hB8};
		run(0);
		expect_pair(5'h00, 16'h0000 - 16'(n_wr));
		$display("wrap test done");
		end_of_test();
	end
endmodule : tb_load_group_decode_execute

`default_nettype wire
